// >>> rtl/comm_seq_pkg.sv
/*
 * shared constants and carrier types for the commutation sequencer:
 * register offsets, field positions, reset values and service timing.
 * assumes a 32-bit avalon-mm slave port with byte addresses.
 */
package comm_seq_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] ADVANCE_OFS = 8'h08;
    localparam logic [7:0] UPPER_OFS = 8'h0C;
    localparam logic [7:0] LOWER_OFS = 8'h10;
    localparam logic [7:0] PERIOD_OFS = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h1C;
    localparam logic [7:0] IRQ_EN_OFS = 8'h20;
    localparam logic [7:0] TABLE_OFS = 8'h40;

    // control register field positions
    localparam int HSR_LSB = 0;
    localparam int PINS_LSB = 4;
    localparam int COUNT_LSB = 8;
    localparam int MASTER_LSB = 16;
    localparam int BUSY_BIT = 31;
    // table entry field positions
    localparam int PAT_LSB = 0;
    localparam int SPAN_LSB = 16;

    // values after reset
    localparam logic [2:0] PINS_RST = 3'h6;
    localparam logic [4:0] COUNT_RST = 5'h06;
    localparam logic [3:0] MASTER_RST = 4'h5;
    localparam logic [15:0] PERIOD_RST = 16'h0100;

    // host service request codes
    localparam logic [1:0] HSR_STOP = 2'h1;
    localparam logic [1:0] HSR_FORCE = 2'h2;
    localparam logic [1:0] HSR_MATCH = 2'h3;

    // service timing in clocks
    localparam logic [7:0] SLOT_SWITCH_TIME = 8'h0A;
    localparam logic [7:0] SVC_BASE = 8'h4A;
    localparam logic [7:0] SVC_PER_PIN = 8'h0E;
    localparam logic [15:0] MATCH_LEAD = 16'h0002;

    localparam int TABLE_LEN = 16;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_SVC = 1'b1
    } seq_state_t;

    typedef enum logic [1:0] {
        K_FORCE = 2'b00,
        K_HALL = 2'b01,
        K_PERIODIC = 2'b10
    } svc_kind_t;

    typedef struct packed {
        logic [8:0] span;
        logic [6:0] pattern;
    } entry_t;

    typedef struct packed {
        logic valid;
        logic [6:0] pattern;
        logic [3:0] master;
        logic [2:0] pins;
        logic [15:0] match;
    } pin_update_t;

endpackage

// >>> rtl/pin_update_stage.sv
/*
 * holds a new output pattern until the base timebase reaches its match
 * value, then drives every slave channel at once.
 * assumes updates come from the sequencer on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_update_stage import comm_seq_pkg::*; (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // update request and time
    input wire pin_update_t i_upd,
    input wire logic [15:0] i_timebase,
    // channel pins
    output logic [15:0] o_chan_pins
);
    pin_update_t pend_ff, nxt_pend;
    logic [15:0] pins_ff, nxt_pins;

    // slaves follow the master, wrapping past channel 15 to low numbers
    function automatic logic [15:0] map_pins(input pin_update_t u);
        logic [15:0] m;
        logic [3:0] ch;
        m = 16'h0000;
        for (int k = 0; k < 7; k++) begin
            ch = u.master + 4'(k + 1);
            if (3'(k) < u.pins) begin
                m[ch] = u.pattern[k];
            end
        end
        return m;
    endfunction

    // one common match value moves every pin on the same edge
    always_comb begin
        nxt_pend = pend_ff;
        nxt_pins = pins_ff;
        if (pend_ff.valid && i_timebase == pend_ff.match) begin
            nxt_pins = map_pins(pend_ff);
            nxt_pend.valid = 1'b0;
        end
        if (i_upd.valid) begin
            nxt_pend = i_upd;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pend_ff <= '0;
            pins_ff <= 16'h0000;
        end else if (i_ce) begin
            pend_ff <= nxt_pend;
            pins_ff <= nxt_pins;
        end
    end

    assign o_chan_pins = pins_ff;

    common_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && pins_ff != nxt_pins) |-> (pend_ff.valid && i_timebase == pend_ff.match))
        else $error("pins changed away from the match value");
endmodule
`default_nettype wire

// >>> rtl/motor_commutation_sequencer.sv
/*
 * commutation sequencer: state table, angle advance, periodic match
 * updates, hall link updates, interrupt status and avalon-mm registers.
 * assumes position count and hall link come from logic on i_ref_clk.
 */
// Overview of operation
// - every completed service raises an interrupt request when its channel is enabled
// - per-channel enable bit gates the interrupt request
// - status bit is set on every service even when disabled
// - signed advance shifts state boundaries against the position count
// - each table entry carries its own span in encoder counts
// - slave channels wrap past channel 15 to low numbers
// - a service takes at most 74 clocks plus 14 per pin
// - the service budget includes a 10-clock slot switch
// - hall mode uses sixteen entries indexed by the decoded state
// - state write plus request 2 forces that state's pattern
// - request 3 starts periodic boundary-matching updates
// - advance sign picks upward or downward stepping
`timescale 1ns/1ps
`default_nettype none
module motor_commutation_sequencer import comm_seq_pkg::*; (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // position and hall decode
    input wire logic [15:0] i_position_count,
    input wire logic i_hall_link,
    input wire logic [3:0] i_hall_state,
    // outputs
    output logic [15:0] o_chan_pins,
    output logic o_irq
);
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [2:0] pins_ff, nxt_pins;
    logic [4:0] count_ff, nxt_count;
    logic [3:0] master_ff, nxt_master;
    logic [3:0] idx_ff, nxt_idx;
    logic [15:0] adv_ff, nxt_adv;
    logic [15:0] upper_ff, nxt_upper;
    logic [15:0] lower_ff, nxt_lower;
    logic [15:0] period_ff, nxt_period;
    logic [15:0] pcnt_ff, nxt_pcnt;
    logic [15:0] stat_ff, nxt_stat;
    logic [15:0] en_ff, nxt_en;
    logic irq_ff, nxt_irq;
    logic [15:0] tb_ff, nxt_tb;
    entry_t tbl_ff [TABLE_LEN];
    entry_t nxt_tbl [TABLE_LEN];
    seq_state_t fsm_ff, nxt_fsm;
    svc_kind_t kind_ff, nxt_kind;
    logic [7:0] scnt_ff, nxt_scnt;
    logic run_ff, nxt_run;
    logic force_pend_ff, nxt_force_pend;
    logic hall_pend_ff, nxt_hall_pend;
    logic per_pend_ff, nxt_per_pend;
    pin_update_t upd_ff, nxt_upd;
    logic access;
    logic done;
    logic [15:0] adj;
    logic [31:0] wmask;

    // modular position compare: a lies beyond b within half a turn
    function automatic logic beyond(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] d;
        d = a - b;
        return !d[15] && d != 16'h0000;
    endfunction

    function automatic logic [3:0] wrap_inc(input logic [3:0] i, input logic [4:0] n);
        return (5'(i) + 5'd1 >= n) ? 4'h0 : i + 4'h1;
    endfunction

    function automatic logic [3:0] wrap_dec(input logic [3:0] i, input logic [4:0] n);
        return (i == 4'h0) ? 4'(n - 5'd1) : i - 4'h1;
    endfunction

    assign access = (i_avs_read || i_avs_write) && !wait_ff;
    assign done = (fsm_ff == S_SVC) && (scnt_ff == 8'h01);
    assign adj = i_position_count + adv_ff;
    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // bus slave, registers and service sequencer share one next-state block
    always_comb begin
        logic [31:0] w;
        logic [3:0] ni;
        w = i_avs_writedata & wmask;
        ni = idx_ff;
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        nxt_pins = pins_ff;
        nxt_count = count_ff;
        nxt_master = master_ff;
        nxt_idx = idx_ff;
        nxt_adv = adv_ff;
        nxt_upper = upper_ff;
        nxt_lower = lower_ff;
        nxt_period = period_ff;
        nxt_pcnt = pcnt_ff;
        nxt_en = en_ff;
        nxt_tbl = tbl_ff;
        nxt_fsm = fsm_ff;
        nxt_kind = kind_ff;
        nxt_scnt = scnt_ff;
        nxt_run = run_ff;
        nxt_force_pend = force_pend_ff;
        nxt_hall_pend = hall_pend_ff;
        nxt_per_pend = per_pend_ff;
        nxt_upd = upd_ff;
        nxt_upd.valid = 1'b0;
        nxt_tb = tb_ff + 16'h0001;
        nxt_stat = stat_ff;
        // one wait cycle, then the access completes
        if ((i_avs_read || i_avs_write) && wait_ff) begin
            nxt_wait = 1'b0;
            nxt_rdata = 32'h0000_0000;
            if (i_avs_address >= TABLE_OFS) begin
                nxt_rdata = 32'(tbl_ff[i_avs_address[5:2]].pattern) << PAT_LSB
                    | 32'(tbl_ff[i_avs_address[5:2]].span) << SPAN_LSB;
            end else begin
                case (i_avs_address)
                    CTRL_OFS: nxt_rdata = 32'(pins_ff) << PINS_LSB
                        | 32'(count_ff) << COUNT_LSB | 32'(master_ff) << MASTER_LSB
                        | 32'(fsm_ff == S_SVC) << BUSY_BIT;
                    STATE_OFS: nxt_rdata = 32'(idx_ff);
                    ADVANCE_OFS: nxt_rdata = 32'(adv_ff);
                    UPPER_OFS: nxt_rdata = 32'(upper_ff);
                    LOWER_OFS: nxt_rdata = 32'(lower_ff);
                    PERIOD_OFS: nxt_rdata = 32'(period_ff);
                    IRQ_STAT_OFS: nxt_rdata = 32'(stat_ff);
                    IRQ_EN_OFS: nxt_rdata = 32'(en_ff);
                    default: nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
        // register writes take effect on the completing edge only
        if (access && i_avs_write) begin
            if (i_avs_address >= TABLE_OFS) begin
                if (i_avs_byteenable[0]) begin
                    nxt_tbl[i_avs_address[5:2]].pattern = w[PAT_LSB +: 7];
                end
                if (i_avs_byteenable[2]) begin
                    nxt_tbl[i_avs_address[5:2]].span = w[SPAN_LSB +: 9];
                end
            end else begin
                case (i_avs_address)
                    CTRL_OFS: begin
                        if (i_avs_byteenable[0]) begin
                            nxt_pins = w[PINS_LSB +: 3];
                            unique case (w[HSR_LSB +: 2])
                                HSR_FORCE: nxt_force_pend = 1'b1;
                                HSR_MATCH: nxt_run = 1'b1;
                                HSR_STOP: nxt_run = 1'b0;
                                default: nxt_run = run_ff;
                            endcase
                        end
                        if (i_avs_byteenable[1]) begin
                            nxt_count = w[COUNT_LSB +: 5];
                        end
                        if (i_avs_byteenable[2]) begin
                            nxt_master = w[MASTER_LSB +: 4];
                        end
                    end
                    STATE_OFS: nxt_idx = (idx_ff & ~wmask[3:0]) | w[3:0];
                    ADVANCE_OFS: nxt_adv = (adv_ff & ~wmask[15:0]) | w[15:0];
                    UPPER_OFS: nxt_upper = (upper_ff & ~wmask[15:0]) | w[15:0];
                    LOWER_OFS: nxt_lower = (lower_ff & ~wmask[15:0]) | w[15:0];
                    PERIOD_OFS: nxt_period = (period_ff & ~wmask[15:0]) | w[15:0];
                    IRQ_CLR_OFS: nxt_stat = stat_ff & ~w[15:0];
                    IRQ_EN_OFS: nxt_en = (en_ff & ~wmask[15:0]) | w[15:0];
                    default: nxt_stat = nxt_stat;
                endcase
            end
        end
        // hall link hands over a decoded state directly
        if (i_hall_link) begin
            nxt_hall_pend = 1'b1;
            nxt_idx = i_hall_state;
        end
        // periodic match timer runs only after the start request
        if (run_ff) begin
            if (pcnt_ff == 16'h0000) begin
                nxt_pcnt = period_ff;
                nxt_per_pend = 1'b1;
            end else begin
                nxt_pcnt = pcnt_ff - 16'h0001;
            end
        end else begin
            nxt_pcnt = period_ff;
            nxt_per_pend = 1'b0;
        end
        unique case (fsm_ff)
            S_IDLE: begin
                if (force_pend_ff || hall_pend_ff || per_pend_ff) begin
                    nxt_fsm = S_SVC;
                    // fixed length: 74-clock base plus 14 clocks of per-pin output work
                    nxt_scnt = SVC_BASE + SVC_PER_PIN * 8'(pins_ff);
                    if (force_pend_ff) begin
                        nxt_kind = K_FORCE;
                        nxt_force_pend = 1'b0;
                    end else if (hall_pend_ff) begin
                        nxt_kind = K_HALL;
                        nxt_hall_pend = 1'b0;
                    end else begin
                        nxt_kind = K_PERIODIC;
                        nxt_per_pend = 1'b0;
                    end
                end
            end
            S_SVC: begin
                nxt_scnt = scnt_ff - 8'h01;
                if (done) begin
                    nxt_fsm = S_IDLE;
                    if (kind_ff == K_PERIODIC) begin
                        if (!adv_ff[15] && beyond(adj, upper_ff)) begin
                            ni = wrap_inc(idx_ff, count_ff);
                            nxt_lower = upper_ff;
                            nxt_upper = upper_ff + 16'(tbl_ff[ni].span);
                        end else if (adv_ff[15] && beyond(lower_ff, adj)) begin
                            ni = wrap_dec(idx_ff, count_ff);
                            nxt_upper = lower_ff;
                            nxt_lower = lower_ff - 16'(tbl_ff[ni].span);
                        end
                        nxt_idx = ni;
                    end
                    nxt_upd.valid = 1'b1;
                    nxt_upd.pattern = tbl_ff[ni].pattern;
                    nxt_upd.master = master_ff;
                    nxt_upd.pins = pins_ff;
                    nxt_upd.match = tb_ff + MATCH_LEAD;
                    // set wins over a same-cycle clear, enabled or not
                    nxt_stat[master_ff] = 1'b1;
                end
            end
        endcase
        nxt_irq = |(nxt_stat & nxt_en);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            pins_ff <= PINS_RST;
            count_ff <= COUNT_RST;
            master_ff <= MASTER_RST;
            idx_ff <= 4'h0;
            adv_ff <= 16'h0000;
            upper_ff <= 16'h0000;
            lower_ff <= 16'h0000;
            period_ff <= PERIOD_RST;
            pcnt_ff <= PERIOD_RST;
            stat_ff <= 16'h0000;
            en_ff <= 16'h0000;
            irq_ff <= 1'b0;
            tb_ff <= 16'h0000;
            tbl_ff <= '{default: '0};
            fsm_ff <= S_IDLE;
            kind_ff <= K_FORCE;
            scnt_ff <= 8'h00;
            run_ff <= 1'b0;
            force_pend_ff <= 1'b0;
            hall_pend_ff <= 1'b0;
            per_pend_ff <= 1'b0;
            upd_ff <= '0;
        end else if (i_ce) begin
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            pins_ff <= nxt_pins;
            count_ff <= nxt_count;
            master_ff <= nxt_master;
            idx_ff <= nxt_idx;
            adv_ff <= nxt_adv;
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
            period_ff <= nxt_period;
            pcnt_ff <= nxt_pcnt;
            stat_ff <= nxt_stat;
            en_ff <= nxt_en;
            irq_ff <= nxt_irq;
            tb_ff <= nxt_tb;
            tbl_ff <= nxt_tbl;
            fsm_ff <= nxt_fsm;
            kind_ff <= nxt_kind;
            scnt_ff <= nxt_scnt;
            run_ff <= nxt_run;
            force_pend_ff <= nxt_force_pend;
            hall_pend_ff <= nxt_hall_pend;
            per_pend_ff <= nxt_per_pend;
            upd_ff <= nxt_upd;
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_irq = irq_ff;

    pin_update_stage u_pins (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_upd(upd_ff),
        .i_timebase(tb_ff),
        .o_chan_pins(o_chan_pins)
    );

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence svc_end_s;
        i_ce && done;
    endsequence

    svc_status_set_a: assert property (svc_end_s |=> stat_ff[$past(master_ff)])
        else $error("service ended without status bit");
    // same-cycle view: a clear write may drop the level on the next edge legally
    irq_gating_a: assert property ((stat_ff & en_ff) != 16'h0000 |-> o_irq)
        else $error("enabled status did not raise irq");
    poll_no_irq_a: assert property (en_ff == 16'h0000 |-> !o_irq)
        else $error("irq raised while all channels disabled");
    step_up_a: assert property (svc_end_s and (kind_ff == K_PERIODIC && !adv_ff[15]
        && beyond(adj, upper_ff)) |=> idx_ff == wrap_inc($past(idx_ff), $past(count_ff)))
        else $error("positive advance did not step state up");
    span_track_a: assert property (svc_end_s and (kind_ff == K_PERIODIC && adv_ff[15]
        && beyond(lower_ff, adj)) |=> upper_ff == $past(lower_ff)
        && lower_ff == $past(lower_ff) - 16'(tbl_ff[idx_ff].span))
        else $error("boundaries not moved by state span");
    svc_budget_a: assert property ($rose(fsm_ff == S_SVC) |->
        scnt_ff <= SVC_BASE + SVC_PER_PIN * 8'(pins_ff) && scnt_ff >= SLOT_SWITCH_TIME)
        else $error("service length outside budget");
    force_pat_a: assert property (svc_end_s and (kind_ff == K_FORCE)
        |=> upd_ff.valid && upd_ff.pattern == tbl_ff[idx_ff].pattern)
        else $error("forced state pattern not issued");
    idx_range_a: assert property (count_ff != 5'd0 && fsm_ff == S_SVC
        && kind_ff == K_PERIODIC |-> 5'(idx_ff) < count_ff || count_ff > 5'd16)
        else $error("state index outside state count");
endmodule
`default_nettype wire

// >>> sim/pos_hall_model.sv
/*
 * behavioural model of the decode logic on the far side of the sequencer:
 * position count source and hall state decoder with its link pulse.
 * assumes the bench commands it on the same rising edge clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pos_hall_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // commands from the bench
    input wire logic [15:0] i_pos_set,
    input wire logic i_hall_req,
    input wire logic [3:0] i_hall_val,
    // decode outputs
    output logic [15:0] o_position_count,
    output logic o_hall_link,
    output logic [3:0] o_hall_state
);
    // state is only meaningful with the link, so it toggles otherwise to expose stale use
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_position_count <= 16'h0000;
            o_hall_link <= 1'b0;
            o_hall_state <= 4'h0;
        end else begin
            o_position_count <= i_pos_set;
            o_hall_link <= i_hall_req & ~o_hall_link;
            o_hall_state <= i_hall_req ? i_hall_val : ~o_hall_state;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb.sv
/*
 * self-checking bench for the commutation sequencer: avalon-mm tasks,
 * forced, hall and periodic services, interrupt and pin mapping checks.
 * assumes the design package and the decode model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb import comm_seq_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic wreq;
    logic [15:0] pins;
    logic irq;
    logic [15:0] pos;
    logic [15:0] pos_set = 16'h0000;
    logic hlink;
    logic hreq = 1'b0;
    logic [3:0] hval = 4'h0;
    logic [3:0] hstate;
    logic [31:0] q;
    int n_errors = 0;
    int n_checks = 0;
    int c;

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    motor_commutation_sequencer i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_ce(1'b1),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_position_count(pos), .i_hall_link(hlink), .i_hall_state(hstate),
        .o_chan_pins(pins), .o_irq(irq));
    pos_hall_model i_model (.i_ref_clk(ref_clk), .i_rst(rst), .i_pos_set(pos_set),
        .i_hall_req(hreq), .i_hall_val(hval), .o_position_count(pos),
        .o_hall_link(hlink), .o_hall_state(hstate));

    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic timed_out();
        n_errors++;
        $display("CHECK FAILED t=%0t wait timed out", $time);
        conclude();
    endtask

    // one access; held until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (wreq === 1'b0) break;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk);
        if (n >= 20) timed_out();
    endtask

    // reads until the masked field matches, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        for (int n = 0; n < 150; n++) begin
            bus(1'b0, a, 32'h0000_0000);
            if ((q & m) === e) break;
        end
        `CHK(q & m, e)
    endtask

    task automatic wait_irq();
        for (c = 0; c < 1000; c++) begin
            @(posedge ref_clk);
            if (irq === 1'b1) break;
        end
        if (c >= 1000) timed_out();
    endtask

    function automatic logic [6:0] pat(input int i);
        return (i == 4) ? 7'h00 : 7'(i * 9 + 1);
    endfunction

    // slave channel k sits at master+1+k, wrapping past channel 15
    function automatic logic [15:0] map(input int m, input int p, input logic [6:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < p; k++) r[(m + 1 + k) % 16] = v[k];
        return r;
    endfunction

    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        poll(CTRL_OFS, 32'hFFFF_FFFF, 32'h0005_0660);
        `CHK(pins, 16'h0000)
        `CHK(irq, 1'b0)
        poll(PERIOD_OFS, 32'hFFFF_FFFF, 32'h0000_0100);
        poll(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
        poll(IRQ_CLR_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int i = 0; i < 16; i++) bus(1'b1, TABLE_OFS + 8'(4 * i), {16'h0032, 9'h0, pat(i)});
        // forced state with the interrupt masked: status still sets
        bus(1'b1, IRQ_EN_OFS, 32'h0000_0000);
        bus(1'b1, STATE_OFS, 32'h0000_0002);
        bus(1'b1, CTRL_OFS, 32'h0005_0662);
        poll(IRQ_STAT_OFS, 32'h0000_0020, 32'h0000_0020);
        `CHK(irq, 1'b0)
        repeat (4) @(posedge ref_clk);
        `CHK(pins, map(5, 6, pat(2)))
        bus(1'b1, IRQ_CLR_OFS, 32'h0000_0020);
        poll(IRQ_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
        // enabled interrupt and service length with six pins
        bus(1'b1, IRQ_EN_OFS, 32'h0000_0020);
        bus(1'b1, STATE_OFS, 32'h0000_0007);
        bus(1'b1, CTRL_OFS, 32'h0005_0662);
        wait_irq();
        `CHK(c <= 74 + 14 * 6 + 3, 1'b1)
        bus(1'b1, IRQ_CLR_OFS, 32'h0000_0020);
        @(posedge ref_clk);
        `CHK(irq, 1'b0)
        // master on channel 14 wraps its slaves to 15, 0, 1
        bus(1'b1, IRQ_EN_OFS, 32'h0000_4000);
        bus(1'b1, CTRL_OFS, 32'h000E_0632);
        wait_irq();
        repeat (4) @(posedge ref_clk);
        `CHK(pins, map(14, 3, pat(7)))
        bus(1'b1, IRQ_CLR_OFS, 32'h0000_4000);
        // hall link: a valid state, then an invalid one that must clear the pins
        bus(1'b1, CTRL_OFS, 32'h0005_0660);
        bus(1'b1, IRQ_EN_OFS, 32'h0000_0020);
        for (int h = 9; h >= 4; h -= 5) begin
            hreq <= 1'b1;
            hval <= 4'(h);
            @(posedge ref_clk);
            hreq <= 1'b0;
            wait_irq();
            repeat (4) @(posedge ref_clk);
            `CHK(pins, map(5, 6, pat(h)))
            bus(1'b1, IRQ_CLR_OFS, 32'h0000_0020);
        end
        // periodic updates, positive advance steps up one state
        bus(1'b1, PERIOD_OFS, 32'h0000_0040);
        bus(1'b1, STATE_OFS, 32'h0000_0000);
        bus(1'b1, UPPER_OFS, 32'h0000_0064);
        bus(1'b1, LOWER_OFS, 32'h0000_0000);
        bus(1'b1, ADVANCE_OFS, 32'h0000_0005);
        pos_set <= 16'h0062;
        bus(1'b1, CTRL_OFS, 32'h0005_0663);
        poll(STATE_OFS, 32'h0000_000F, 32'h0000_0001);
        poll(UPPER_OFS, 32'h0000_FFFF, 32'h0000_0096);
        // stop, twelve states, negative advance wraps below entry zero
        bus(1'b1, CTRL_OFS, 32'h0005_0C61);
        poll(CTRL_OFS, 32'h8000_0000, 32'h0000_0000);
        bus(1'b1, STATE_OFS, 32'h0000_0000);
        bus(1'b1, UPPER_OFS, 32'h0000_0032);
        bus(1'b1, LOWER_OFS, 32'h0000_0000);
        bus(1'b1, ADVANCE_OFS, 32'h0000_FFFB);
        pos_set <= 16'h0002;
        bus(1'b1, CTRL_OFS, 32'h0005_0C63);
        poll(STATE_OFS, 32'h0000_000F, 32'h0000_000B);
        poll(LOWER_OFS, 32'h0000_FFFF, 32'h0000_FFCE);
        conclude();
    end
endmodule
`default_nettype wire
